// File: dv/client_model.sv
// Client completer logic model consuming the request stream
`timescale 1ns/10ps
`default_nettype none
module client_model
  import req_stream_pkg::*;
(
  input  wire logic         i_sys_clk, // Clock
  input  wire logic         i_arst_n,  // Async reset
  input  wire logic         i_valid,   // Stream valid
  input  wire logic [127:0] i_data,    // Stream data
  input  wire logic [3:0]   i_keep,    // Dword keep
  input  wire logic         i_eop,     // Last beat
  input  wire sideband_t    i_sb,      // Sideband
  input  wire logic         i_stall,   // Slow client
  output logic              o_ready    // Client ready
);
  logic [1:0]   phase;
  logic [173:0] beats[$];
  logic [127:0] owed[$];

  //**********************************************************
  // Ready pattern: three of four cycles low when slow
  //**********************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase   <= 2'h0;
      o_ready <= 1'b0;
    end else begin
      phase   <= phase + 2'h1;
      o_ready <= !i_stall || (phase == 2'h3);
    end
  end

  //**********************************************************
  // Record every accepted beat
  //**********************************************************
  always @(posedge i_sys_clk) begin
    if (i_arst_n && i_valid && o_ready) begin
      beats.push_back({i_sb, i_eop, i_keep, i_data});
      // Each read owes one whole completion, queued in arrival order
      if (i_sb.sop && i_data[TYPE_POS +: 4] == TYPE_MEM_RD)
        owed.push_back(i_data);
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_completer_request_stream_delivery.sv
// Testbench for the completer request stream framer
`timescale 1ns/10ps
`default_nettype none
module tb_completer_request_stream_delivery
  import req_stream_pkg::*;
;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  rx_req_t      rq = '0;
  logic         rqv = 1'b0;
  logic [127:0] pd = '0;
  logic         pv = 1'b0;
  apb_req_t     ap = '0;
  logic         stall = 1'b0;
  logic         rx_ready, pay_ready, s_valid, s_ready, s_eop;
  logic [127:0] s_data;
  logic [3:0]   s_keep;
  sideband_t    s_sb;
  logic [31:0]  prdata;
  logic         pready, pslverr;
  logic [32:0]  r;
  logic [173:0] b0;
  int           n_fail = 0;
  int           cmp_count = 0;
  logic [10:0]  cn [4] = '{11'h001, 11'h002, 11'h008, 11'h001};
  logic [3:0]   fb [4] = '{4'hF, 4'h5, 4'hE, 4'h0};
  logic [3:0]   lb [4] = '{4'h0, 4'hA, 4'h7, 4'h0};

  always #12.5 clk = ~clk;

  req_stream_framer req_stream_framer_i (
    .i_sys_clk                  (clk),
    .i_arst_n                   (arst_n),
    .i_rx_req                   (rq),
    .i_rx_req_valid             (rqv),
    .o_rx_req_ready             (rx_ready),
    .i_rx_pay_data              (pd),
    .i_rx_pay_valid             (pv),
    .o_rx_pay_ready             (pay_ready),
    .o_req_stream_data          (s_data),
    .o_req_stream_valid         (s_valid),
    .i_req_stream_ready         (s_ready),
    .o_req_stream_dword_keep    (s_keep),
    .o_req_stream_end_of_packet (s_eop),
    .o_req_stream_sideband      (s_sb),
    .i_apb                      (ap),
    .o_prdata                   (prdata),
    .o_pready                   (pready),
    .o_pslverr                  (pslverr)
  );

  client_model client_model_i (
    .i_sys_clk (clk),
    .i_arst_n  (arst_n),
    .i_valid   (s_valid),
    .i_data    (s_data),
    .i_keep    (s_keep),
    .i_eop     (s_eop),
    .i_sb      (s_sb),
    .i_stall   (stall),
    .o_ready   (s_ready)
  );

  //**********************************************************
  // Helpers
  //**********************************************************
  task automatic results();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [173:0] s, input logic [173:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [127:0] dsc(input logic [3:0] t,
                                       input logic [10:0] c,
                                       input logic [1:0] a);
    return {49'h0, t, c, 60'h123456789ABCDEF, a, 2'b00};
  endfunction

  function automatic logic [173:0] mk(input logic [127:0] d,
    input logic [3:0] k, input logic e, input logic sop,
    input logic [31:0] be, input logic [3:0] l, input logic [3:0] f);
    return {sop, be, l, f, e, k, d};
  endfunction

  // Dwords outside keep carry no meaning
  function automatic logic [173:0] got();
    logic [173:0] b;
    b = client_model_i.beats.pop_front();
    for (int i = 0; i < 4; i++) begin
      if (!b[128+i]) b[32*i+:32] = 32'h0;
    end
    return b;
  endfunction

  task automatic wait_beats(input int n);
    int k;
    k = 0;
    while (client_model_i.beats.size() < n && k < 300) begin
      @(posedge clk);
      k++;
    end
    if (k == 300) n_fail++;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd);
    ap <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:wd};
    @(posedge clk);
    ap.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = {pslverr, prdata};
    ap <= '0;
    @(posedge clk);
  endtask

  task automatic xfer(input logic [127:0] d, input logic [3:0] f,
    input logic [3:0] l, input logic [127:0] p, input logic hp,
    input logic more);
    rq  <= '{desc:d, first_dword_enables:f, last_dword_enables:l};
    rqv <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    if (!more) rqv <= 1'b0;
    if (hp) begin
      pd <= p;
      pv <= 1'b1;
      do @(posedge clk); while (pay_ready !== 1'b1);
      pv <= 1'b0;
    end
  endtask

  task automatic wr2(input logic [127:0] d, input logic [3:0] f,
    input logic [3:0] l, input logic [127:0] p, input logic [173:0] e1);
    xfer(d, f, l, p, 1'b1, 1'b0);
    wait_beats(2);
    check(got(), mk(d, 4'hF, 1'b0, 1'b1, 32'h0, l, f));
    check(got(), e1);
  endtask

  //**********************************************************
  // Sequence
  //**********************************************************
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(174'(r), 174'(33'h0));
    apb(1'b0, STATUS_OFS, 32'h0);
    check(174'(r), 174'(33'h0));
    apb(1'b0, 12'h008, 32'h0);
    check(174'(r), 174'(33'h1_0000_0000));
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(dsc(TYPE_MEM_RD, cn[i], 2'(i)), fb[i], lb[i], '0, 1'b0, i < 3);
    end
    wait_beats(4);
    for (int i = 0; i < 4; i++) begin
      b0 = mk(dsc(TYPE_MEM_RD, cn[i], 2'(i)), 4'hF, 1'b1, 1'b1, 32'h0,
              lb[i], fb[i]);
      check(got(), b0);
    end
    check(174'(client_model_i.owed.size()), 174'(4));
    stall <= 1'b0;
    wr2(dsc(TYPE_MEM_WR, 11'h001, 2'h2), 4'h6, 4'h0,
        {96'h0, 32'hCAFE0001},
        mk({96'h0, 32'hCAFE0001}, 4'h1, 1'b1, 1'b0, 32'h6, 4'h0,
           4'h0));
    apb(1'b1, CTRL_OFS, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(174'(r), 174'(33'h1));
    stall <= 1'b1;
    wr2(dsc(TYPE_MEM_WR, 11'h002, 2'h3), 4'h5, 4'h3,
        {64'h0, 32'hB0B00002, 32'hA0A00001},
        mk({32'hA0A00001, 96'h0}, 4'hF, 1'b0, 1'b0, 32'h5000, 4'h0,
           4'h0));
    wait_beats(1);
    check(got(), mk({96'h0, 32'hB0B00002}, 4'h1, 1'b1, 1'b0, 32'h3,
                    4'h0, 4'h0));
    wr2(dsc(TYPE_MEM_WR, 11'h001, 2'h0), 4'h0, 4'h0,
        {96'h0, 32'h5A5A5A5A},
        mk({96'h0, 32'h5A5A5A5A}, 4'h1, 1'b1, 1'b0, 32'h0, 4'h0,
           4'h0));
    wr2(dsc(TYPE_IO_WR, 11'h001, 2'h1), 4'hF, 4'h0,
        {96'h0, 32'h10C0FFEE},
        mk({64'h0, 32'h10C0FFEE, 32'h0}, 4'h3, 1'b1, 1'b0, 32'hF0,
           4'h0, 4'h0));
    repeat (4) @(posedge clk);
    apb(1'b0, STATUS_OFS, 32'h0);
    check(174'(r), 174'(33'h0_0008_0000));
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire

// File: inc/req_stream_pkg.sv
// Constants and types for the completer request stream framer
package req_stream_pkg;
  //**********************************************************
  // Port geometry
  //**********************************************************
  localparam int DATA_W  = 128;
  localparam int DW_BEAT = 4;
  localparam int CNT_W   = 11;
  //**********************************************************
  // Descriptor fields
  //**********************************************************
  localparam int ADDR_DW_POS = 2;
  localparam int DWCNT_POS   = 64;
  localparam int TYPE_POS    = 75;
  localparam logic [3:0] TYPE_MEM_RD = 4'h0;
  localparam logic [3:0] TYPE_MEM_WR = 4'h1;
  localparam logic [3:0] TYPE_IO_WR  = 4'h3;
  //**********************************************************
  // Register map
  //**********************************************************
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam int          CTRL_MODE_BIT = 0;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_CNT_POS  = 16;
  localparam logic        CTRL_MODE_RST = 1'b0;
  localparam logic [15:0] PKT_CNT_RST   = 16'h0000;

  typedef enum logic {MODE_DWORD, MODE_ADDR} placement_mode_t;

  typedef struct packed {
    logic [127:0] desc;
    logic [3:0]   first_dword_enables;
    logic [3:0]   last_dword_enables;
  } rx_req_t;

  typedef struct packed {
    logic        sop;
    logic [31:0] byte_en;
    logic [3:0]  last_dword_enables;
    logic [3:0]  first_dword_enables;
  } sideband_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// File: rtl/req_stream_framer.sv
// Completer request stream framer, 128-bit port
`timescale 1ns/10ps
`default_nettype none
module req_stream_framer
  import req_stream_pkg::*;
(
  input  wire logic         i_sys_clk,                  // System clock
  input  wire logic         i_arst_n,                   // Async reset
  input  wire rx_req_t      i_rx_req,                   // Request header
  input  wire logic         i_rx_req_valid,             // Header valid
  output logic              o_rx_req_ready,             // Header taken
  input  wire logic [127:0] i_rx_pay_data,              // Payload beat
  input  wire logic         i_rx_pay_valid,             // Payload valid
  output logic              o_rx_pay_ready,             // Payload taken
  output logic [127:0]      o_req_stream_data,          // Stream data
  output logic              o_req_stream_valid,         // Stream valid
  input  wire logic         i_req_stream_ready,         // Client ready
  output logic [3:0]        o_req_stream_dword_keep,    // Dword keep
  output logic              o_req_stream_end_of_packet, // Last beat
  output sideband_t         o_req_stream_sideband,      // Sideband
  input  wire apb_req_t     i_apb,                      // APB request
  output logic [31:0]       o_prdata,                   // APB read data
  output logic              o_pready,                   // APB ready
  output logic              o_pslverr                   // APB error
);
  typedef enum logic {ST_IDLE, ST_PAY} state_t;

  //**********************************************************
  // Helpers
  //**********************************************************
  function automatic logic [3:0] dw_enables(
    input logic [10:0] g,
    input logic [10:0] total,
    input logic [3:0]  fbe,
    input logic [3:0]  lbe
  );
    logic [3:0] r;
    r = 4'hF;
    if (g == 11'h000)
      r = fbe;
    else if (g == total - 11'h001)
      r = lbe;
    return r;
  endfunction

  function automatic logic contig(input logic [3:0] be);
    logic [4:0] s;
    s = {1'b0, be} + {1'b0, be & (~be + 4'h1)};
    return (({1'b0, be} & s) == 5'h00);
  endfunction

  state_t            state;
  placement_mode_t   mode;
  logic              out_load;
  logic              desc_go;
  logic              pay_go;
  logic              need_in;
  logic              pay_last;
  logic              first_pay;
  logic [10:0]       total;
  logic [10:0]       sent;
  logic [10:0]       next_sent;
  logic [1:0]        off;
  logic [3:0]        fbe;
  logic [3:0]        lbe;
  logic [95:0]       carry;
  logic [127:0]      next_data;
  logic [3:0]        next_keep;
  logic [15:0]       next_be;
  logic [3:0]        rq_type;
  logic [10:0]       rq_cnt;
  logic              rq_pay;
  logic [15:0]       pkt_cnt;

  //**********************************************************
  // Register file
  //**********************************************************
  req_stream_regs u_regs (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_apb     (i_apb),
    .o_prdata  (o_prdata),
    .o_pready  (o_pready),
    .o_pslverr (o_pslverr),
    .i_busy    ((state != ST_IDLE) || o_req_stream_valid),
    .i_pkt_cnt (pkt_cnt),
    .o_mode    (mode)
  );

  //**********************************************************
  // Request decode
  //**********************************************************
  assign rq_type = i_rx_req.desc[TYPE_POS +: 4];
  assign rq_pay  = (rq_type == TYPE_MEM_WR) || (rq_type == TYPE_IO_WR);
  assign rq_cnt  = (rq_type == TYPE_IO_WR) ? 11'h001 :
                   i_rx_req.desc[DWCNT_POS +: CNT_W];

  // Output stage loads when empty or beat accepted
  assign out_load = !o_req_stream_valid || i_req_stream_ready;

  assign o_rx_req_ready = (state == ST_IDLE) && out_load;
  assign desc_go        = o_rx_req_ready && i_rx_req_valid;

  //**********************************************************
  // Payload beat assembly
  //**********************************************************
  always_comb begin
    logic [1:0]  gap;
    logic [10:0] g;
    logic [10:0] left;
    logic [10:0] avail;
    g         = 11'h000;
    left      = 11'h000;
    avail     = 11'h000;
    gap       = first_pay ? off : 2'h0;
    next_data = '0;
    next_keep = 4'h0;
    next_be   = 16'h0000;
    for (int p = 0; p < DW_BEAT; p++) begin
      g = sent + 11'(p) - {9'h000, gap};
      if (p < int'(gap)) begin
        next_keep[p] = 1'b1;
      end else if (g < total) begin
        next_keep[p] = 1'b1;
        if (p < int'(off))
          next_data[p*32 +: 32] = carry[p*32 +: 32];
        else
          next_data[p*32 +: 32] =
            i_rx_pay_data[(p - int'(off))*32 +: 32];
        next_be[p*4 +: 4] = dw_enables(g, total, fbe, lbe);
      end
    end
    left      = total - sent;
    avail     = 11'(DW_BEAT) - {9'h000, gap};
    next_sent = sent + ((left < avail) ? left : avail);
  end

  assign pay_last = next_sent == total;
  assign need_in  = first_pay || ((total - sent) > {9'h000, off});
  assign o_rx_pay_ready = (state == ST_PAY) && out_load && need_in;
  assign pay_go = (state == ST_PAY) && out_load &&
                  (!need_in || i_rx_pay_valid);

  //**********************************************************
  // Sequencing
  //**********************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state     <= ST_IDLE;
      total     <= 11'h000;
      sent      <= 11'h000;
      off       <= 2'h0;
      first_pay <= 1'b0;
      fbe       <= 4'h0;
      lbe       <= 4'h0;
    end else if (desc_go) begin
      total     <= rq_cnt;
      sent      <= 11'h000;
      first_pay <= 1'b1;
      fbe       <= i_rx_req.first_dword_enables;
      lbe       <= i_rx_req.last_dword_enables;
      off       <= (mode == MODE_ADDR) ?
                   i_rx_req.desc[ADDR_DW_POS +: 2] : 2'h0;
      if (rq_pay)
        state <= ST_PAY;
    end else if (pay_go) begin
      sent      <= next_sent;
      first_pay <= 1'b0;
      if (pay_last)
        state <= ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      carry <= 96'h0;
    else if (pay_go && need_in)
      carry <= 96'(i_rx_pay_data >> (32 * (DW_BEAT - int'(off))));
  end

  //**********************************************************
  // Output stage
  //**********************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_req_stream_valid         <= 1'b0;
      o_req_stream_data          <= '0;
      o_req_stream_dword_keep    <= 4'h0;
      o_req_stream_end_of_packet <= 1'b0;
      o_req_stream_sideband      <= '0;
    end else if (out_load) begin
      o_req_stream_valid <= desc_go || pay_go;
      if (desc_go) begin
        o_req_stream_data          <= i_rx_req.desc;
        o_req_stream_dword_keep    <= 4'hF;
        o_req_stream_end_of_packet <= !rq_pay;
        o_req_stream_sideband.sop  <= 1'b1;
        o_req_stream_sideband.byte_en <= 32'h0000_0000;
        o_req_stream_sideband.first_dword_enables <=
          i_rx_req.first_dword_enables;
        o_req_stream_sideband.last_dword_enables <=
          i_rx_req.last_dword_enables;
      end else if (pay_go) begin
        o_req_stream_data          <= next_data;
        o_req_stream_dword_keep    <= next_keep;
        o_req_stream_end_of_packet <= pay_last;
        o_req_stream_sideband.sop  <= 1'b0;
        o_req_stream_sideband.byte_en <= {16'h0000, next_be};
        o_req_stream_sideband.first_dword_enables <= 4'h0;
        o_req_stream_sideband.last_dword_enables  <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      pkt_cnt <= PKT_CNT_RST;
    else if (o_req_stream_valid && i_req_stream_ready &&
             o_req_stream_end_of_packet)
      pkt_cnt <= pkt_cnt + 16'h0001;
  end

  //**********************************************************
  // Assertions
  //**********************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  sequence beat_stalled;
    o_req_stream_valid && !i_req_stream_ready;
  endsequence

  sequence beat_taken_mid;
    o_req_stream_valid && i_req_stream_ready &&
    !o_req_stream_end_of_packet;
  endsequence

  sequence sop_beat;
    o_req_stream_valid && o_req_stream_sideband.sop;
  endsequence

  sop_on_desc_a: assert property (
    desc_go |=> o_req_stream_valid && o_req_stream_sideband.sop &&
                o_req_stream_data == $past(i_rx_req.desc))
    else $error("descriptor beat missing start flag");

  beat_hold_a: assert property (
    beat_stalled |=> o_req_stream_valid &&
                     $stable(o_req_stream_data) &&
                     $stable(o_req_stream_dword_keep))
    else $error("stalled beat changed data or keep");

  side_hold_a: assert property (
    beat_stalled |=> $stable(o_req_stream_sideband) &&
                     $stable(o_req_stream_end_of_packet))
    else $error("stalled beat changed sideband or end");

  pkt_unbroken_a: assert property (
    beat_taken_mid |=> o_req_stream_valid)
    else $error("valid dropped inside a packet");

  read_single_a: assert property (
    sop_beat and (o_req_stream_data[TYPE_POS +: 4] == TYPE_MEM_RD)
      |-> o_req_stream_end_of_packet &&
          o_req_stream_dword_keep == 4'hF)
    else $error("read packet not a single descriptor beat");

  pay_fresh_a: assert property (
    sop_beat and (o_req_stream_data[TYPE_POS +: 4] == TYPE_MEM_WR)
      |-> !o_req_stream_end_of_packet &&
          o_req_stream_sideband.byte_en == 32'h0000_0000)
    else $error("write payload shares the descriptor beat");

  keep_full_a: assert property (
    o_req_stream_valid && o_req_stream_dword_keep != 4'hF
      |-> o_req_stream_end_of_packet)
    else $error("keep gap outside the last beat");

  last_flag_a: assert property (
    pay_go && pay_last |=> o_req_stream_valid &&
                           o_req_stream_end_of_packet)
    else $error("end flag missing on final beat");

  first_lane_a: assert property (
    pay_go && first_pay && (mode == MODE_ADDR) |=>
      o_req_stream_sideband.byte_en[{off, 2'b00} +: 4] == fbe &&
      o_req_stream_dword_keep[off])
    else $error("first payload byte on wrong lane");

  zero_len_a: assert property (
    pay_go && first_pay && total == 11'h001 && fbe == 4'h0
      |=> o_req_stream_sideband.byte_en == 32'h0000_0000 &&
          o_req_stream_end_of_packet)
    else $error("zero-length write carries byte enables");

  io_one_a: assert property (
    desc_go && rq_type == TYPE_IO_WR |=> total == 11'h001 &&
      state == ST_PAY && first_pay)
    else $error("I/O write payload not one Dword");

  rd_enables_a: assert property (
    desc_go |=> o_req_stream_sideband.first_dword_enables ==
                  $past(i_rx_req.first_dword_enables) &&
                o_req_stream_sideband.last_dword_enables ==
                  $past(i_rx_req.last_dword_enables))
    else $error("Dword enables not on descriptor beat");

  rd_contig_a: assert property (
    sop_beat and (o_req_stream_data[TYPE_POS +: 4] == TYPE_MEM_RD) and
    (o_req_stream_data[DWCNT_POS +: CNT_W] > 11'h002)
      |-> contig(o_req_stream_sideband.first_dword_enables) &&
          contig(o_req_stream_sideband.last_dword_enables))
    else $error("long read with non-contiguous enables");

  gap_keep_a: assert property (
    pay_go && first_pay |=>
      (o_req_stream_dword_keep | (4'hF << off)) == 4'hF &&
      (o_req_stream_sideband.byte_en[15:0] &
       ~(16'hFFFF << {off, 2'b00})) == 16'h0000)
    else $error("gap before payload lost keep or has enables");

  fresh_beat_a: assert property (
    desc_go && rq_pay |=> o_req_stream_valid &&
                          o_req_stream_sideband.sop &&
                          !o_req_stream_end_of_packet &&
                          o_req_stream_sideband.byte_en == 32'h0000_0000)
    else $error("payload started inside the descriptor beat");

  zero_read_a: assert property (
    sop_beat and (o_req_stream_data[TYPE_POS +: 4] == TYPE_MEM_RD) and
    (o_req_stream_sideband.first_dword_enables == 4'h0)
      |-> o_req_stream_data[DWCNT_POS +: CNT_W] == 11'h001 &&
          o_req_stream_sideband.last_dword_enables == 4'h0)
    else $error("zero-length read not count one with no enables");

  mode_place_a: assert property (
    desc_go && mode == MODE_DWORD |=> off == 2'h0)
    else $error("Dword placement with a lane offset");

  pay_cont_a: assert property (
    pay_go && !pay_last |=> o_req_stream_valid &&
                           !o_req_stream_end_of_packet)
    else $error("end flag before the final payload beat");
endmodule
`default_nettype wire

// File: rtl/req_stream_regs.sv
// APB register file for the request stream framer
`timescale 1ns/10ps
`default_nettype none
module req_stream_regs
  import req_stream_pkg::*;
(
  input  wire logic            i_sys_clk,  // System clock
  input  wire logic            i_arst_n,   // Async reset
  input  wire apb_req_t        i_apb,      // APB request
  output logic [31:0]          o_prdata,   // Read data
  output logic                 o_pready,   // Transfer done
  output logic                 o_pslverr,  // Unmapped address
  input  wire logic            i_busy,     // Framer busy
  input  wire logic [15:0]     i_pkt_cnt,  // Packets delivered
  output placement_mode_t      o_mode      // Placement mode
);
  logic access;
  logic hit_ctrl;
  logic hit_stat;

  assign access   = i_apb.psel && i_apb.penable;
  assign hit_ctrl = i_apb.paddr == CTRL_OFS;
  assign hit_stat = i_apb.paddr == STATUS_OFS;

  //**********************************************************
  // One wait state, answer from flops
  //**********************************************************
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= access && !o_pready;
      o_pslverr <= access && !o_pready && !hit_ctrl && !hit_stat;
      o_prdata  <= 32'h0000_0000;
      if (access && !o_pready && !i_apb.pwrite) begin
        if (hit_ctrl)
          o_prdata[CTRL_MODE_BIT] <= o_mode;
        if (hit_stat) begin
          o_prdata[STAT_BUSY_BIT]       <= i_busy;
          o_prdata[STAT_CNT_POS +: 16]  <= i_pkt_cnt;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      o_mode <= placement_mode_t'(CTRL_MODE_RST);
    else if (access && o_pready && i_apb.pwrite && hit_ctrl)
      o_mode <= placement_mode_t'(i_apb.pwdata[CTRL_MODE_BIT]);
  end
endmodule
`default_nettype wire
